// ===== common/timer0_consts.vh
// constants for the 8-bit timer/counter and its shared prescaler
// assumes one instruction cycle of four clk_sys periods (Q1..Q4)
`ifndef TIMER0_CONSTS_VH
`define TIMER0_CONSTS_VH

// ==========================================================
// file register map
`define TMR_ADDR 5'h01
`define FILE_ADDR_W 5

// ==========================================================
// option_config fields
`define OPT_WAKE_BIT 7
`define OPT_PULLUP_BIT 6
`define OPT_CSS_BIT 5
`define OPT_CES_BIT 4
`define OPT_PSA_BIT 3
`define OPT_PS_HI 2
`define OPT_PS_LO 0
`define OPT_RESET 8'hff

// ==========================================================
// pin direction
`define TRIS_W 4
`define TRIS_RESET 4'hf
`define TCKI_PIN 2

// ==========================================================
// instruction cycle phases, one clk_sys each
`define PHASE_Q1 2'h0
`define PHASE_Q2 2'h1
`define PHASE_Q3 2'h2
`define PHASE_Q4 2'h3

// ==========================================================
// timing
`define INHIBIT_CYCLES 2'h2
`define ARM_CYCLES 3'h7
`define TMR_POR_VALUE 8'h00
`define PRE_RESET 8'h00

`endif

// ===== rtl/prescaler8.v
// shared prescaler counter with ratio tap select
// assumes step and clear are single-cycle pulses on clk_sys
`timescale 1ns/100ps
`include "timer0_consts.vh"

module prescaler8 #(
    parameter PRE_WIDTH = 8
) (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // control
    input wire clear,
    input wire step,
    input wire [2:0] ratio,
    // tapped output level
    output wire tap
);

    // ======================================================
    // tap decode
    function tap_of;
        input [PRE_WIDTH-1:0] cnt;
        input [2:0] sel;
        begin
            tap_of = cnt[sel];
        end
    endfunction

    reg [PRE_WIDTH-1:0] cnt_q;
    reg [PRE_WIDTH-1:0] cnt_d;

    // ======================================================
    // counter, no path to software
    always @* begin
        cnt_d = cnt_q;
        if (clear) begin
            cnt_d = {PRE_WIDTH{1'b0}};
        end else if (step) begin
            cnt_d = cnt_q + {{(PRE_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q <= `PRE_RESET; // [RULE9]
        end else begin
            cnt_q <= cnt_d; // [RULE7] [RULE8]
        end
    end

    // tap n rises once per 2^(n+1) steps
    assign tap = tap_of(cnt_q, ratio); // [RULE21]

endmodule

// ===== rtl/timer0_prescaler.v
// 8-bit timer/counter with a prescaler shared with the watchdog
// assumes the core supplies file, option and direction write strobes
// aligned to clk_sys; clk_sys is the oscillator, four per instruction
//
// Contract
// [RULE1] source select clear: count once per instruction cycle, no prescaler
// [RULE2] after a timer write, increments held off for two cycles
// [RULE3] source select set: counter mode on external count pin edges
// [RULE4] edge select clear counts rising edges, set counts falling
// [RULE5] one prescaler, serving timer when assign clear, watchdog when set
// [RULE6] prescaler on timer divides 1:2 to 1:256 in powers of two
// [RULE7] prescaler is an 8-bit counter, timer prescaler or watchdog postscaler
// [RULE8] no read or write path to the prescaler counter
// [RULE9] device reset clears every prescaler bit
// [RULE10] timer writes clear prescaler while it serves the timer
// [RULE11] watchdog clear op clears prescaler while it serves the watchdog
// [RULE12] counter mode forces the count pin to input
// [RULE13] without prescaler the count input is the prescaler output
// [RULE14] prescaler output sampled in Q2 and Q4 before timer increments
// [RULE15] far end holds count input high and low two oscillator periods
// [RULE16] with prescaler, count period at least four periods over ratio; here the pin is filtered before the prescaler, so four periods at any ratio
// [RULE17] timer increments three to seven periods after an input change
// [RULE18] software order for moving prescaler from timer to watchdog
// [RULE19] software order for moving prescaler from watchdog to timer
// [RULE20] timer count at address 01h, read and write, kept across reset
// [RULE21] ratio code 000 divides by 2, each step doubles, 111 by 256
// [RULE22] after reset: counter mode, falling edge, prescaler on watchdog
`timescale 1ns/100ps
`include "timer0_consts.vh"

module timer0_prescaler #(
    parameter CNT_WIDTH = 8,
    parameter PRE_WIDTH = 8
) (
    // clock and resets
    input wire clk_sys,
    input wire rst,
    input wire por,
    // file register access
    input wire [4:0] file_addr,
    input wire file_wr,
    input wire [7:0] file_wdata,
    input wire file_rd,
    output wire [7:0] file_rdata,
    output wire file_hit,
    // option and direction loads
    input wire option_wr,
    input wire [7:0] option_wdata,
    input wire tris_wr,
    input wire [3:0] tris_wdata,
    // watchdog
    input wire watchdog_clear_op,
    input wire watchdog_tick,
    output wire watchdog_expire,
    // pins
    input wire external_count_input,
    output wire [3:0] pin_output_enable,
    // status to the core
    output wire [1:0] q_phase,
    output wire instr_cycle_end,
    output wire [7:0] option_state
);

    // ======================================================
    // declarations
    reg [1:0] phase_q;
    reg [7:0] option_q;
    reg [3:0] tris_q;
    reg [CNT_WIDTH-1:0] timer_count_q;
    reg [CNT_WIDTH-1:0] timer_count_d;
    reg [7:0] rdata_q;
    reg [1:0] inhibit_q;
    reg [1:0] inhibit_d;
    reg ext_s1_q;
    reg ext_s2_q;
    reg ext_s3_q;
    reg ext_level_q;
    reg sel_prev_q;
    reg samp_q;
    reg wdt_tap_prev_q;
    reg watchdog_expire_q;
    reg watchdog_expire_d;
    reg pres_step;
    reg pres_clear;
    reg pres_out;
    reg timer_inc;
    reg [2:0] arm_q;
    reg [2:0] arm_d;

    wire count_source_select;
    wire count_edge_select;
    wire prescaler_assign;
    wire [2:0] prescale_ratio;
    wire cycle_end;
    wire sample_phase;
    wire tmr_write;
    wire sel_level;
    wire sel_rise;
    wire pres_tap;
    wire [3:0] dir_eff;
    wire armed;

    // ======================================================
    // option fields
    assign count_source_select = option_q[`OPT_CSS_BIT];
    assign count_edge_select = option_q[`OPT_CES_BIT];
    assign prescaler_assign = option_q[`OPT_PSA_BIT];
    assign prescale_ratio = option_q[`OPT_PS_HI:`OPT_PS_LO];

    // ======================================================
    // instruction cycle phases
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phase_q <= `PHASE_Q1;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    assign cycle_end = (phase_q == `PHASE_Q4);
    assign sample_phase = (phase_q == `PHASE_Q2) ||
        (phase_q == `PHASE_Q4); // [RULE14]

    // ======================================================
    // option and direction registers
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            option_q <= `OPT_RESET; // [RULE22]
        end else if (option_wr) begin
            option_q <= option_wdata;
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tris_q <= `TRIS_RESET;
        end else if (tris_wr) begin
            tris_q <= tris_wdata;
        end
    end

    // counter mode forces the count pin to input
    genvar gi;
    generate
        for (gi = 0; gi < `TRIS_W; gi = gi + 1) begin : g_dir
            if (gi == `TCKI_PIN) begin : g_tcki
                assign dir_eff[gi] = tris_q[gi] |
                    count_source_select; // [RULE12]
            end else begin : g_plain
                assign dir_eff[gi] = tris_q[gi];
            end
        end
    endgenerate

    assign pin_output_enable = ~dir_eff;

    // ======================================================
    // external count input synchroniser
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
            ext_level_q <= 1'b0;
        end else begin
            ext_s1_q <= external_count_input;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            if (ext_s2_q == ext_s3_q) begin
                ext_level_q <= ext_s3_q;
            end
        end
    end

    // ======================================================
    // edge arming after reset
    // synchroniser and samplers reset to fixed levels, not to the
    // pin; edges are held off until they have seen the real level,
    // so an idle pin gives no false count after reset
    always @* begin
        arm_d = arm_q;
        if (arm_q != `ARM_CYCLES) begin
            arm_d = arm_q + 3'h1;
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            arm_q <= 3'h0;
        end else begin
            arm_q <= arm_d;
        end
    end

    assign armed = (arm_q == `ARM_CYCLES);

    // falling edges become rising edges of the inverted level
    assign sel_level = ext_level_q ^ count_edge_select; // [RULE4]
    assign sel_rise = sel_level & ~sel_prev_q & armed;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sel_prev_q <= 1'b0;
        end else begin
            sel_prev_q <= sel_level;
        end
    end

    // ======================================================
    // shared prescaler
    assign tmr_write = file_wr && (file_addr == `TMR_ADDR);

    always @* begin
        pres_step = 1'b0;
        pres_clear = 1'b0;
        if (!prescaler_assign) begin
            // serving the timer
            if (count_source_select) begin
                pres_step = sel_rise; // [RULE3]
            end else begin
                pres_step = cycle_end;
            end
            pres_clear = tmr_write; // [RULE10]
        end else begin
            // serving the watchdog
            pres_step = watchdog_tick; // [RULE5]
            pres_clear = watchdog_clear_op; // [RULE11]
        end
    end

    prescaler8 #(
        .PRE_WIDTH(PRE_WIDTH)
    ) u_prescaler (
        .clk_sys(clk_sys),
        .rst(rst),
        .clear(pres_clear),
        .step(pres_step),
        .ratio(prescale_ratio),
        .tap(pres_tap)
    );

    // ======================================================
    // prescaler output toward the timer
    always @* begin
        if (!prescaler_assign) begin
            pres_out = pres_tap; // [RULE6]
        end else begin
            pres_out = sel_level; // [RULE13]
        end
    end

    // sampled in Q2 and Q4; a rising sample increments the timer
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            samp_q <= 1'b0;
        end else if (sample_phase) begin
            samp_q <= pres_out; // [RULE14]
        end
    end

    always @* begin
        timer_inc = 1'b0;
        if (!count_source_select && prescaler_assign) begin
            timer_inc = cycle_end; // [RULE1]
        end else if (count_source_select || !prescaler_assign) begin
            timer_inc = sample_phase && pres_out && !samp_q &&
                armed; // [RULE17]
        end
    end

    // ======================================================
    // write inhibit
    always @* begin
        inhibit_d = inhibit_q;
        if (tmr_write) begin
            inhibit_d = `INHIBIT_CYCLES; // [RULE2]
        end else if (cycle_end && (inhibit_q != 2'h0)) begin
            inhibit_d = inhibit_q - 2'h1;
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            inhibit_q <= 2'h0;
        end else begin
            inhibit_q <= inhibit_d;
        end
    end

    // ======================================================
    // timer count, reset only at power-on
    always @* begin
        timer_count_d = timer_count_q;
        if (tmr_write) begin
            timer_count_d = file_wdata[CNT_WIDTH-1:0]; // [RULE20]
        end else if (timer_inc && (inhibit_q == 2'h0)) begin
            timer_count_d = timer_count_q +
                {{(CNT_WIDTH-1){1'b0}}, 1'b1}; // [RULE2]
        end
    end

    always @(posedge clk_sys or posedge por) begin
        if (por) begin
            timer_count_q <= `TMR_POR_VALUE;
        end else begin
            timer_count_q <= timer_count_d; // [RULE20]
        end
    end

    // ======================================================
    // read path, registered one cycle after the strobe
    assign file_hit = (file_addr == `TMR_ADDR);

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (file_rd && file_hit) begin
            rdata_q <= timer_count_q; // [RULE20]
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign file_rdata = rdata_q;

    // ======================================================
    // watchdog postscaler output
    always @* begin
        watchdog_expire_d = 1'b0;
        if (prescaler_assign) begin
            watchdog_expire_d = pres_tap && !wdt_tap_prev_q; // [RULE7]
        end else begin
            watchdog_expire_d = watchdog_tick; // [RULE5]
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wdt_tap_prev_q <= 1'b0;
            watchdog_expire_q <= 1'b0;
        end else begin
            wdt_tap_prev_q <= pres_tap;
            watchdog_expire_q <= watchdog_expire_d;
        end
    end

    assign watchdog_expire = watchdog_expire_q;

    // ======================================================
    // status to the core
    assign q_phase = phase_q;
    assign instr_cycle_end = cycle_end;
    assign option_state = option_q;

endmodule

// ===== verif/timer0_props.sv
// assertions on the timer/counter top ports
// assumes one clk_sys domain with async active-high rst
`timescale 1ns/100ps

module timer0_props (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // registers
    input wire [4:0] file_addr,
    input wire file_rd,
    input wire [7:0] file_rdata,
    input wire file_hit,
    input wire option_wr,
    input wire [7:0] option_wdata,
    input wire tris_wr,
    input wire [3:0] tris_wdata,
    input wire [7:0] option_state,
    // status and pins
    input wire watchdog_tick,
    input wire watchdog_expire,
    input wire [3:0] pin_output_enable,
    input wire [1:0] q_phase,
    input wire instr_cycle_end
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // ========
    // properties
    a_hit_decode: assert property (
        file_hit == (file_addr == 5'h01)) else $error("hit decode");
    a_read_idle: assert property (
        !(file_rd && file_hit) |=> file_rdata == 8'h00)
        else $error("read data not idle");
    a_phase_walk: assert property (
        1'b1 |=> q_phase == $past(q_phase) + 2'h1)
        else $error("phase skipped");
    a_q4_flag: assert property (
        instr_cycle_end == (q_phase == 2'h3)) else $error("q4 flag");
    a_pin_force: assert property (
        option_state[5] |-> !pin_output_enable[2])
        else $error("count pin driven");
    a_tris_load: assert property (
        tris_wr && !option_wr |=> pin_output_enable ==
        (~$past(tris_wdata) & {1'b1, !option_state[5], 2'b11}))
        else $error("direction load");
    a_option_load: assert property (
        option_wr |=> option_state == $past(option_wdata))
        else $error("option load");
    a_direct_wdt: assert property (
        watchdog_tick && !option_state[3] && !option_wr |=> watchdog_expire)
        else $error("unscaled watchdog tick lost");
    c_read: cover property (file_rd && file_hit);
    c_expire: cover property (watchdog_expire);
    c_counter: cover property (option_wr && option_wdata[5]);
endmodule

bind timer0_prescaler timer0_props u_timer0_props (
    .clk_sys, .rst, .file_addr, .file_rd, .file_rdata, .file_hit,
    .option_wr, .option_wdata, .tris_wr, .tris_wdata, .option_state,
    .watchdog_tick, .watchdog_expire, .pin_output_enable, .q_phase,
    .instr_cycle_end
);

// ===== verif/count_source.sv
// count pin source for counter mode
// assumes start is a one-cycle pulse and half stays put while busy
`timescale 1ns/100ps

module count_source (
    // clock
    input wire clk_sys,
    // request
    input wire start,
    input wire [10:0] toggles,
    input wire [3:0] half,
    // pin side
    output reg pin,
    output wire busy
);
    reg [10:0] left_q = 11'h000;
    reg [3:0] wait_q = 4'h0;
    initial pin = 1'b0;
    assign busy = (left_q != 11'h000);
    // ========
    // each level held half cycles, half of 3 or more
    always @(posedge clk_sys) begin
        if (start) begin
            left_q <= toggles;
            wait_q <= half;
        end else if (busy) begin
            if (wait_q > 4'h1) begin
                wait_q <= wait_q - 4'h1;
            end else begin
                wait_q <= half;
                left_q <= left_q - 11'h001;
                pin <= ~pin;
            end
        end
    end
endmodule

// ===== verif/tb_timer0_prescaler.sv
// self-checking bench for the timer/counter and its prescaler
// assumes count_source on the count pin and the bound checker
`timescale 1ns/100ps
`include "timer0_consts.vh"

module tb_timer0_prescaler;
    typedef struct {
        logic [7:0] opt;
        int n;
        int h;
        logic [7:0] exp;
    } row_t;
    row_t rows [10];
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic por = 1'b1;
    logic [4:0] file_addr = '0;
    logic file_wr = 1'b0;
    logic [7:0] file_wdata = '0;
    logic file_rd = 1'b0;
    logic option_wr = 1'b0;
    logic [7:0] option_wdata = '0;
    logic tris_wr = 1'b0;
    logic [3:0] tris_wdata = '0;
    logic watchdog_clear_op = 1'b0;
    logic watchdog_tick = 1'b0;
    logic start = 1'b0;
    logic [10:0] toggles = '0;
    logic [3:0] half = 4'h3;
    logic [7:0] n_exp = '0;
    logic [7:0] v;
    logic [7:0] b;
    int fails = 0;
    int total_checks = 0;
    wire [7:0] file_rdata;
    wire file_hit;
    wire watchdog_expire;
    wire [3:0] pin_output_enable;
    wire [1:0] q_phase;
    wire instr_cycle_end;
    wire [7:0] option_state;
    wire external_count_input;
    wire busy;

    timer0_prescaler u_timer0_prescaler (
        .clk_sys, .rst, .por, .file_addr, .file_wr, .file_wdata,
        .file_rd, .file_rdata, .file_hit, .option_wr, .option_wdata,
        .tris_wr, .tris_wdata, .watchdog_clear_op, .watchdog_tick,
        .watchdog_expire, .external_count_input, .pin_output_enable,
        .q_phase, .instr_cycle_end, .option_state
    );
    count_source u_count_source (
        .clk_sys, .start, .toggles, .half,
        .pin(external_count_input), .busy
    );

    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (watchdog_expire === 1'b1) n_exp <= n_exp + 1;

    // ========
    // tasks
    task step;
        @(posedge clk_sys);
        #1;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("Error t=%0t got %h exp %h", $time, got, exp);
            fails++;
        end
    endtask
    task wr(input logic [4:0] a, input logic [7:0] d);
        file_addr = a;
        file_wdata = d;
        file_wr = 1'b1;
        step;
        file_wr = 1'b0;
        step;
    endtask
    task rd(input logic [4:0] a, output logic [7:0] d);
        file_addr = a;
        file_rd = 1'b1;
        step;
        file_rd = 1'b0;
        d = file_rdata;
        step;
    endtask
    task opt(input logic [7:0] d);
        watchdog_clear_op = 1'b1;
        step;
        watchdog_clear_op = 1'b0;
        option_wdata = d;
        option_wr = 1'b1;
        step;
        option_wr = 1'b0;
        step;
    endtask
    task wd(input bit c);
        if (c) watchdog_clear_op = 1'b1;
        else watchdog_tick = 1'b1;
        step;
        watchdog_clear_op = 1'b0;
        watchdog_tick = 1'b0;
        repeat (2) step;
    endtask
    task final_report;
        $display("checks %0d errors %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // ========
    // sequence
    initial begin
        #2_000_000;
        fails++;
        final_report;
    end
    initial begin
        rows = '{'{8'h28, 5, 3, 8'h03}, '{8'h38, 5, 8, 8'h03},
            '{8'h20, 8, 3, 8'h02}, '{8'h21, 16, 4, 8'h02},
            '{8'h22, 32, 3, 8'h02}, '{8'h23, 64, 3, 8'h02},
            '{8'h24, 128, 3, 8'h02}, '{8'h25, 256, 3, 8'h02},
            '{8'h26, 512, 3, 8'h02}, '{8'h27, 1024, 3, 8'h02}};
        repeat (12) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        por = 1'b0;
        chk(option_state, 8'hff);
        chk(pin_output_enable, 4'h0);
        rd(`TMR_ADDR, v);
        chk(v, 8'h00);
        option_wdata = 8'h08;
        option_wr = 1'b1;
        step;
        option_wr = 1'b0;
        wd(0);
        chk(n_exp, 8'h01);
        foreach (rows[i]) begin
            opt(rows[i].opt);
            wr(`TMR_ADDR, 8'h00);
            repeat (16) step;
            toggles = 11'(rows[i].n);
            half = 4'(rows[i].h);
            start = 1'b1;
            step;
            start = 1'b0;
            for (int k = 0; k < 20000 && busy; k++) step;
            chk({7'h00, busy}, 8'h00);
            repeat (12) step;
            rd(`TMR_ADDR, v);
            chk(v, rows[i].exp);
        end
        wd(1);
        wr(`TMR_ADDR, 8'h00);
        opt(8'h08);
        tris_wr = 1'b1;
        step;
        tris_wr = 1'b0;
        chk(pin_output_enable, 4'hf);
        while (q_phase !== 2'h0) step;
        wr(`TMR_ADDR, 8'hfe);
        repeat (14) step;
        rd(`TMR_ADDR, v);
        chk(v, 8'h00);
        opt(8'h28);
        chk(pin_output_enable, 4'hb);
        wr(`TMR_ADDR, 8'h5a);
        wr(5'h02, 8'ha5);
        rd(5'h02, v);
        chk(v, 8'h00);
        rst = 1'b1;
        repeat (2) step;
        rst = 1'b0;
        chk(option_state, 8'hff);
        repeat (12) step;
        rd(`TMR_ADDR, v);
        chk(v, 8'h5a);
        wr(`TMR_ADDR, 8'h00);
        opt(8'h08);
        wd(1);
        b = n_exp;
        wd(0);
        chk(n_exp, b + 8'h01);
        wd(1);
        wd(0);
        chk(n_exp, b + 8'h02);
        wr(`TMR_ADDR, 8'h00);
        wd(0);
        chk(n_exp, b + 8'h02);
        opt(8'h00);
        wd(0);
        chk(n_exp, b + 8'h03);
        final_report;
    end
endmodule
